// *** rtl/motor_pwm.sv ***
// Motor PWM time base, override, fault handling and A/D trigger.
//
// What this block does
// RULE1 - mode 10 is single pulse, edge-aligned only
// RULE2 - single pulse: active on enable, off at duty
// RULE3 - period match: clear counter, outputs, enable; interrupt
// RULE4 - override upper byte selects, lower byte levels
// RULE5 - overridden low pin complements high, dead time kept; this block inserts no dead time
// RULE6 - sync override at zero, also period when centered
// RULE7 - reset pin cfg 0 drives inactive, 1 tri-states; with cfg 0 this block drives complementary low sides active while stopped outside single pulse
// RULE8 - one polarity bit high side, one low side
// RULE9 - per-pin enables; clear releases pin to GPIO
// RULE10 - fault with no pair enables has no effect; this block still raises the wake interrupt for such a fault in sleep
// RULE11 - per-pin fault state bits, polarity relative
// RULE12 - complementary fault: high side wins over low
// RULE13 - fault A state beats fault B state
// RULE14 - latched fault: needs pin high and flag cleared
// RULE15 - cycle fault: hold while low, resume at boundary
// RULE16 - per-fault mode bit picks latched or cycle
// RULE17 - lockout blocks duty and period transfers
// RULE18 - immediate update bypasses lockout, not period
// RULE19 - trigger on compare match, direction phase select
// RULE20 - four-bit postscaler one to sixteen matches
// RULE21 - postscaler cleared on compare write, reset
// RULE22 - fault low during sleep raises wake interrupt
// RULE23 - pair mode bit clear complementary, set independent
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "motor_pwm_params.svh"
module motor_pwm (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fault pins, active low, and the sleep status of the processor.
    input wire logic faultInputA_n,
    input wire logic faultInputB_n,
    input wire logic sleepMode,
    // Output pins with their enables.
    output logic [3:0] highSideOutput,
    output logic [3:0] highSideOe,
    output logic [3:0] lowSideOutput,
    output logic [3:0] lowSideOe,
    // Event pulses.
    output logic timeBaseIrq,
    output logic adcTrigger,
    output logic wakeIrq
);
    // ----------------------------------------
    // Registers and internal state
    // ----------------------------------------
    logic [15:0] timeBaseControl; // Enable and mode field.
    logic [14:0] timeBaseCounter; // Running count.
    motor_pwm_pkg::count_dir_type countDir; // Up or down phase.
    logic [14:0] periodBuf; // Software copy of the period.
    logic [14:0] period; // Period in use.
    logic [15:0] adcTriggerCompare; // Trigger value and direction.
    logic [15:0] firstControl; // Pair modes and pin enables.
    logic [15:0] secondControl; // Postscale, immediate, sync, lockout.
    logic [15:0] faultControl [2]; // Index 0 is fault A, 1 is fault B.
    logic [15:0] outputOverrideControl; // Software copy of override.
    logic [15:0] overrideActive; // Override values in effect.
    logic [15:0] dutyBuf [4]; // Software duty values.
    logic [15:0] duty [4]; // Duty values in use.
    logic [2:0] configBits; // Polarities and reset pin state.
    logic [1:0] faultFlag; // Sticky fault flags.
    logic [1:0] faultActive; // Fault override currently applied.
    logic [3:0] postCount; // Postscaler count.
    logic driveStarted; // Set once the time base has run.
    logic [1:0] faultSync; // Synchronised fault pins.
    logic [1:0] faultLow; // Enabled fault asserted.
    logic wr; // Write strobe.
    logic [9:0] idx; // Word index of the access.
    logic tbEnable;
    motor_pwm_pkg::tb_mode_type tbMode;
    logic centered;
    logic zeroHit;
    logic periodMatch;
    logic boundary;
    logic trigMatch;
    logic [3:0] next_highActive;
    logic [3:0] next_lowActive;

    // Picks the high or low bit of a pair from a byte laid out H/L per pair.
    function automatic logic pairBit(input logic [15:0] r, input int lsb,
                                     input int pair, input logic high);
        pairBit = r[lsb + 2 * pair + int'(high)];
    endfunction : pairBit

    // Tells whether a word index names a duty register.
    function automatic logic isDuty(input logic [9:0] i, input int n);
        isDuty = (i == 10'(`IDX_DUTY0 + 2 * n));
    endfunction : isDuty

    // ----------------------------------------
    // Decode and shared terms
    // ----------------------------------------
    assign idx = paddr[11:2];
    assign wr = psel && penable && pwrite && pready;
    assign tbEnable = timeBaseControl[`TB_EN_BIT];
    assign tbMode = motor_pwm_pkg::tb_mode_type'(timeBaseControl[1:0]);
    assign centered = (tbMode == motor_pwm_pkg::TB_UPDOWN)
        || (tbMode == motor_pwm_pkg::TB_UPDOWN_DBL);
    assign zeroHit = tbEnable && (timeBaseCounter == 15'h0000);
    assign periodMatch = tbEnable && (timeBaseCounter == period);
    // Cycle boundary is zero; centered modes add the period match.
    assign boundary = zeroHit || (centered && periodMatch);

    // Fault sampled through two flops before any use.
    pin_sync #(.WIDTH(2)) faultSyncInst (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn({faultInputB_n, faultInputA_n}),
        .pinOut(faultSync)
    );

    // A fault counts only when its input has at least one pair enabled.
    assign faultLow[0] = !faultSync[0] && (|faultControl[0][3:0]); // RULE10
    assign faultLow[1] = !faultSync[1] && (|faultControl[1][3:0]); // RULE10

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // One access cycle: ready and read data are loaded at the end of the setup cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                case (idx)
                    `IDX_TB_CTRL: prdata[15:0] <= timeBaseControl;
                    `IDX_TB_COUNT: prdata[15:0] <= {countDir, timeBaseCounter};
                    `IDX_PERIOD: prdata[14:0] <= periodBuf;
                    `IDX_TRIG_CMP: prdata[15:0] <= adcTriggerCompare;
                    `IDX_CTRL_ONE: prdata[15:0] <= firstControl;
                    `IDX_CTRL_TWO: prdata[15:0] <= secondControl;
                    `IDX_FAULT_A: prdata[15:0] <= faultControl[0];
                    `IDX_FAULT_B: prdata[15:0] <= faultControl[1];
                    `IDX_OVERRIDE: prdata[15:0] <= outputOverrideControl;
                    `IDX_STATUS: prdata[1:0] <= faultFlag;
                    `IDX_CONFIG: prdata[2:0] <= configBits;
                    default: begin
                        // Duty registers, else an error for an unmapped word.
                        if (isDuty(idx, 0)) prdata[15:0] <= dutyBuf[0];
                        else if (isDuty(idx, 1)) prdata[15:0] <= dutyBuf[1];
                        else if (isDuty(idx, 2)) prdata[15:0] <= dutyBuf[2];
                        else if (isDuty(idx, 3)) prdata[15:0] <= dutyBuf[3];
                        else pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Plain control registers written by software.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adcTriggerCompare <= 16'h0000;
            firstControl <= `RST_CTRL_ONE; // RULE23
            secondControl <= 16'h0000;
            faultControl[0] <= 16'h0000;
            faultControl[1] <= 16'h0000;
            outputOverrideControl <= `RST_OVERRIDE;
            configBits <= `RST_CONFIG; // RULE7
        end else if (wr) begin
            case (idx)
                `IDX_TRIG_CMP: adcTriggerCompare <= pwdata[15:0];
                `IDX_CTRL_ONE: firstControl <= {4'h0, pwdata[11:0]};
                `IDX_CTRL_TWO: secondControl <= {4'h0, pwdata[11:8], 5'h00, pwdata[2:0]};
                `IDX_FAULT_A: faultControl[0] <= {pwdata[15:7], 3'h0, pwdata[3:0]};
                `IDX_FAULT_B: faultControl[1] <= {pwdata[15:7], 3'h0, pwdata[3:0]};
                `IDX_OVERRIDE: outputOverrideControl <= pwdata[15:0];
                `IDX_CONFIG: configBits <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    // Enable is cleared by hardware at the end of a single pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeBaseControl <= 16'h0000;
        end else if (wr && idx == `IDX_TB_CTRL) begin
            timeBaseControl <= {pwdata[15], 13'h0000, pwdata[1:0]};
        end else if (periodMatch && tbMode == motor_pwm_pkg::TB_SINGLE) begin
            timeBaseControl[`TB_EN_BIT] <= 1'b0; // RULE3
        end
    end

    // Counter: up-only in free and single modes, up/down when centered.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeBaseCounter <= 15'h0000;
            countDir <= motor_pwm_pkg::DIR_UP;
        end else if (tbEnable) begin
            if (!centered) begin
                countDir <= motor_pwm_pkg::DIR_UP; // RULE1
                if (periodMatch) timeBaseCounter <= 15'h0000; // RULE3
                else timeBaseCounter <= timeBaseCounter + 15'h0001;
            end else if (countDir == motor_pwm_pkg::DIR_UP) begin
                if (periodMatch) begin
                    countDir <= motor_pwm_pkg::DIR_DOWN;
                    timeBaseCounter <= timeBaseCounter - 15'h0001;
                end else begin
                    timeBaseCounter <= timeBaseCounter + 15'h0001;
                end
            end else if (zeroHit) begin
                countDir <= motor_pwm_pkg::DIR_UP;
                timeBaseCounter <= timeBaseCounter + 15'h0001;
            end else begin
                timeBaseCounter <= timeBaseCounter - 15'h0001;
            end
        end
    end

    // Period buffer moves into use at a boundary or while stopped, with lockout clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periodBuf <= `RST_PERIOD;
            period <= `RST_PERIOD;
        end else begin
            if (wr && idx == `IDX_PERIOD) periodBuf <= pwdata[14:0];
            // Immediate update has no say over the period.
            if (!secondControl[`LOCKOUT_BIT] && (boundary || !tbEnable)) begin // RULE17 RULE18
                period <= periodBuf;
            end
        end
    end

    // Duty buffers; immediate update writes straight through lockout.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                dutyBuf[i] <= 16'h0000;
                duty[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr && isDuty(idx, i)) begin
                    dutyBuf[i] <= pwdata[15:0];
                    if (secondControl[`IMM_UPDATE_BIT]) duty[i] <= pwdata[15:0]; // RULE18
                end else if (!secondControl[`LOCKOUT_BIT] && (boundary || !tbEnable)) begin
                    duty[i] <= dutyBuf[i]; // RULE17
                end
            end
        end
    end

    // Period-match pulse serves as the time-base interrupt.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) timeBaseIrq <= 1'b0;
        else timeBaseIrq <= periodMatch; // RULE3
    end

    // ----------------------------------------
    // Override synchronisation
    // ----------------------------------------
    // With sync set, new override values wait for a cycle boundary.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) overrideActive <= `RST_OVERRIDE;
        else if (!secondControl[`SYNC_OVR_BIT] || boundary) begin // RULE6
            overrideActive <= outputOverrideControl;
        end
    end

    // ----------------------------------------
    // Faults
    // ----------------------------------------
    // Flags set while low, cleared by writing one; a set wins the clear.
    // Fault hold starts at once and ends only at a boundary.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faultFlag <= 2'h0;
            faultActive <= 2'h0;
        end else begin
            for (int f = 0; f < 2; f++) begin
                if (faultLow[f]) faultFlag[f] <= 1'b1; // RULE14
                else if (wr && idx == `IDX_STATUS && pwdata[f]) faultFlag[f] <= 1'b0;
                if (faultLow[f]) begin
                    faultActive[f] <= 1'b1; // RULE15
                end else if (boundary && (faultControl[f][`FAULT_MODE_BIT]
                                          || !faultFlag[f])) begin // RULE16
                    faultActive[f] <= 1'b0; // RULE14 RULE15
                end
            end
        end
    end

    // Any fault pin low while asleep raises the wake interrupt.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) wakeIrq <= 1'b0;
        else wakeIrq <= sleepMode && !(faultSync[0] && faultSync[1]); // RULE22
    end

    // ----------------------------------------
    // Special event trigger
    // ----------------------------------------
    // Direction bit chooses the counting phase only when centered.
    assign trigMatch = tbEnable && (timeBaseCounter == adcTriggerCompare[14:0])
        && (!centered || (adcTriggerCompare[`TRIG_DIR_BIT]
                          == (countDir == motor_pwm_pkg::DIR_DOWN))); // RULE19

    // Postscaler passes one trigger per field value plus one matches.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            postCount <= 4'h0; // RULE21
            adcTrigger <= 1'b0;
        end else begin
            adcTrigger <= 1'b0;
            if (wr && idx == `IDX_TRIG_CMP) begin
                postCount <= 4'h0; // RULE21
            end else if (trigMatch) begin
                if (postCount == secondControl[`POST_LSB+3:`POST_LSB]) begin // RULE20
                    postCount <= 4'h0;
                    adcTrigger <= 1'b1;
                end else begin
                    postCount <= postCount + 4'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // Output pair logic
    // ----------------------------------------
    // Compare, then override, then fault, all in active-level terms.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            logic cmp;
            logic comp;
            cmp = tbEnable && ({1'b0, timeBaseCounter} < duty[i]); // RULE2
            comp = !firstControl[`PAIR_MODE_LSB + i]; // RULE23
            next_highActive[i] = cmp;
            next_lowActive[i] = comp ? !cmp : cmp;
            if (tbMode == motor_pwm_pkg::TB_SINGLE && !tbEnable) begin
                next_lowActive[i] = 1'b0; // RULE3
            end
            if (pairBit(overrideActive, 8, i, 1'b1)) begin // RULE4
                next_highActive[i] = pairBit(overrideActive, 0, i, 1'b1);
            end
            if (pairBit(overrideActive, 8, i, 1'b0)) begin // RULE4
                next_lowActive[i] = pairBit(overrideActive, 0, i, 1'b0);
                if (comp && next_lowActive[i]) next_lowActive[i] = !next_highActive[i]; // RULE5
            end
            if (faultActive[0] && faultControl[0][i]) begin // RULE13
                next_highActive[i] = pairBit(faultControl[0], `STATE_LSB, i, 1'b1); // RULE11
                next_lowActive[i] = pairBit(faultControl[0], `STATE_LSB, i, 1'b0);
            end else if (faultActive[1] && faultControl[1][i]) begin
                next_highActive[i] = pairBit(faultControl[1], `STATE_LSB, i, 1'b1); // RULE11
                next_lowActive[i] = pairBit(faultControl[1], `STATE_LSB, i, 1'b0);
            end
            if (comp && (faultActive[0] && faultControl[0][i]
                         || faultActive[1] && faultControl[1][i])
                && next_highActive[i]) begin
                next_lowActive[i] = 1'b0; // RULE12
            end
        end
    end

    // Pins: polarity applied, enables gated until the drive is allowed.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            driveStarted <= 1'b0;
            highSideOutput <= 4'h0;
            lowSideOutput <= 4'h0;
            highSideOe <= 4'h0;
            lowSideOe <= 4'h0;
        end else begin
            if (tbEnable) driveStarted <= 1'b1;
            highSideOutput <= ~(next_highActive ^ {4{configBits[`CFG_HIGH_POL_BIT]}}); // RULE8
            lowSideOutput <= ~(next_lowActive ^ {4{configBits[`CFG_LOW_POL_BIT]}}); // RULE8
            // A clear pin-state bit drives the pins at once; while stopped, complementary low sides are active unless in single pulse.
            if (!configBits[`CFG_PIN_BIT] || driveStarted) begin // RULE7
                highSideOe <= firstControl[`PEN_H_LSB+3:`PEN_H_LSB]; // RULE9
                lowSideOe <= firstControl[3:0]; // RULE9
            end else begin
                highSideOe <= 4'h0;
                lowSideOe <= 4'h0;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    single_end_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        periodMatch && tbMode == motor_pwm_pkg::TB_SINGLE && !wr
        |=> !tbEnable && timeBaseIrq ##1 lowSideOutput == ~{4{configBits[`CFG_LOW_POL_BIT]}}
        || overrideActive[15:8] != 8'h00 || faultActive != 2'h0)
        else $error("Single pulse did not end at period match");
    override_sync_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        secondControl[`SYNC_OVR_BIT] && !boundary |=> $stable(overrideActive))
        else $error("Override changed away from a boundary");
    duty_lock_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
        secondControl[`LOCKOUT_BIT] && !secondControl[`IMM_UPDATE_BIT] |=> $stable(duty[0]))
        else $error("Duty moved under lockout");
    period_lock_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
        secondControl[`LOCKOUT_BIT] |=> $stable(period))
        else $error("Period moved under lockout");
    post_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
        wr && idx == `IDX_TRIG_CMP |=> postCount == 4'h0 && !adcTrigger)
        else $error("Postscaler not cleared by compare write");
    sleep_wake_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
        sleepMode && !faultSync[0] |=> wakeIrq)
        else $error("No wake interrupt for fault in sleep");
    fault_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        faultLow[0] |=> faultFlag[0] && faultActive[0])
        else $error("Fault A low did not set flag and hold");
    fault_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        faultActive[1] && !boundary |=> faultActive[1])
        else $error("Fault B hold ended off a boundary");
endmodule : motor_pwm

// *** rtl/motor_pwm_params.svh ***
// Constant definitions for the motor PWM override, fault and trigger block.
`ifndef MOTOR_PWM_PARAMS_SVH
`define MOTOR_PWM_PARAMS_SVH
// ----------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------
`define IDX_TB_CTRL 10'h1C0
`define IDX_TB_COUNT 10'h1C2
`define IDX_PERIOD 10'h1C4
`define IDX_TRIG_CMP 10'h1C6
`define IDX_CTRL_ONE 10'h1C8
`define IDX_CTRL_TWO 10'h1CA
`define IDX_FAULT_A 10'h1D0
`define IDX_FAULT_B 10'h1D2
`define IDX_OVERRIDE 10'h1D4
`define IDX_DUTY0 10'h1D6
`define IDX_STATUS 10'h1E0
`define IDX_CONFIG 10'h1E2
// ----------------------------------------
// Field positions.
// ----------------------------------------
`define TB_EN_BIT 15
`define TRIG_DIR_BIT 15
`define PAIR_MODE_LSB 8
`define PEN_H_LSB 4
`define IMM_UPDATE_BIT 2
`define SYNC_OVR_BIT 1
`define LOCKOUT_BIT 0
`define POST_LSB 8
`define FAULT_MODE_BIT 7
`define STATE_LSB 8
`define CFG_HIGH_POL_BIT 0
`define CFG_LOW_POL_BIT 1
`define CFG_PIN_BIT 2
// ----------------------------------------
// Reset values.
// ----------------------------------------
`define RST_PERIOD 15'h7FFF
`define RST_CTRL_ONE 16'h00FF
`define RST_OVERRIDE 16'hFF00
`define RST_CONFIG 3'h7
`endif

// *** rtl/motor_pwm_pkg.sv ***
// Types shared by the motor PWM block.
package motor_pwm_pkg;
    // Time-base counting modes as held in the mode field.
    typedef enum logic [1:0] {
        TB_FREE = 2'h0,
        TB_UPDOWN = 2'h1,
        TB_SINGLE = 2'h2,
        TB_UPDOWN_DBL = 2'h3
    } tb_mode_type;
    // Counting direction of the time base, one bit so Gray by nature.
    typedef enum logic {
        DIR_UP = 1'h0,
        DIR_DOWN = 1'h1
    } count_dir_type;
endpackage : motor_pwm_pkg

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for asynchronous input pins.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Raw pins and their synchronised copies.
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] stage; // First stage, read only by the second.

    // Both stages reset high, the idle level of the active-low pins.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= {WIDTH{1'b1}};
            pinOut <= {WIDTH{1'b1}};
        end else begin
            stage <= pinIn;
            pinOut <= stage;
        end
    end
endmodule : pin_sync

// *** tb/fault_sense.sv ***
// Behavioural fault sensing circuit that drives the two fault pins.
`timescale 1ns/1ps
module fault_sense (
    // Clock.
    input wire logic clk,
    // Trip requests from the bench.
    input wire logic tripA,
    input wire logic tripB,
    // Active-low fault pins, idle high.
    output logic faultA_n,
    output logic faultB_n
);
    // A pin stays low for as long as its trip is asked for; the pins are
    // high by the first edge, while the design's synchroniser is still held.
    always @(posedge clk) begin
        faultA_n <= !tripA;
        faultB_n <= !tripB;
    end
endmodule : fault_sense

// *** tb/tb_top.sv ***
// Self-checking bench for the motor PWM override, fault and trigger block.
`timescale 1ns/1ps
module tb_top;
    // Bench signals; stimulus, table and counters given values at time zero.
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, err, sleepMode = 1'h0, tripA = 1'h0, tripB = 1'h0;
    logic faultA_n, faultB_n, irq, trig, wake;
    logic [3:0] hOut, hOe, lOut, lOe;
    int error_cnt = 0, num_checks = 0, n = 0;
    // Rows: address, write data, write flag, expected read.
    logic [44:0] rows [6] = '{{12'h710, 16'h0, 1'h0, 16'h7FFF},
        {12'h720, 16'h0, 1'h0, 16'h00FF}, {12'h750, 16'h0, 1'h0, 16'hFF00},
        {12'h788, 16'h0, 1'h0, 16'h0007}, {12'h718, 16'h8123, 1'h1, 16'h8123},
        {12'h728, 16'h0F00, 1'h1, 16'h0F00}};
    // The 100 ns clock.
    always #50 clk = ~clk;
    fault_sense u_fault (.clk, .tripA, .tripB, .faultA_n, .faultB_n);
    motor_pwm u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .faultInputA_n(faultA_n),
        .faultInputB_n(faultB_n), .sleepMode, .highSideOutput(hOut),
        .highSideOe(hOe), .lowSideOutput(lOut), .lowSideOe(lOe),
        .timeBaseIrq(irq), .adcTrigger(trig), .wakeIrq(wake));
    // One APB transfer; holds the request until pready is seen high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb
    task wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'h1, a, {16'h0, d});
        repeat (4) @(posedge clk);
    endtask : wr
    // Compares a seen value with the expected one.
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task test_done;
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // Watchdog against a hung handshake.
    initial begin
        #400000;
        error_cnt++;
        test_done;
    end
    // Main sequence.
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk({28'h0, hOe}, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            if (rows[i][16]) apb(1'h1, rows[i][44:33], {16'h0, rows[i][32:17]});
            apb(1'h0, rows[i][44:33], 32'h0);
            chk(rdata, {16'h0, rows[i][15:0]});
            $display("row %0d done", i);
        end
        apb(1'h0, 12'h7FC, 32'h0);
        chk({err, rdata[30:0]}, 32'h80000000);
        wr(12'h788, 16'h3);
        chk({24'h0, hOe, lOe}, 32'hFF);
        wr(12'h720, 16'h00F0);
        chk({24'h0, hOe, lOe}, 32'hF0);
        wr(12'h720, 16'h00FF);
        wr(12'h750, 16'hFF03);
        chk({24'h0, hOut, lOut}, 32'h10);
        wr(12'h720, 16'h01FF);
        chk({24'h0, hOut, lOut}, 32'h11);
        wr(12'h788, 16'h0);
        chk({24'h0, hOut, lOut}, 32'hEE);
        wr(12'h788, 16'h3);
        wr(12'h750, 16'h0);
        wr(12'h720, 16'h00FF);
        $display("override test done");
        wr(12'h740, 16'h0201);
        wr(12'h748, 16'h0081);
        tripA <= 1'h1;
        tripB <= 1'h1;
        sleepMode <= 1'h1;
        repeat (6) @(posedge clk);
        chk({27'h0, hOut, wake}, 32'h3);
        tripA <= 1'h0;
        tripB <= 1'h0;
        sleepMode <= 1'h0;
        repeat (6) @(posedge clk);
        chk({28'h0, hOut}, 32'h1);
        wr(12'h780, 16'h3);
        // Flag cleared, but a stopped time base gives no boundary to resume at.
        chk({28'h0, hOut}, 32'h1);
        $display("fault test done");
        wr(12'h710, 16'h0014);
        wr(12'h758, 16'h0005);
        apb(1'h1, 12'h700, 32'h8002);
        repeat (2) @(posedge clk);
        chk({28'h0, hOut}, 32'h1);
        repeat (6) @(posedge clk);
        chk({28'h0, hOut}, 32'h0);
        for (int i = 0; i < 100 && irq !== 1'h1; i++) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'h0, 12'h700, 32'h0);
        chk(rdata, 32'h0002);
        apb(1'h0, 12'h708, 32'h0);
        chk(rdata, 32'h0);
        chk({28'h0, hOut}, 32'h0);
        $display("single pulse test done");
        // Up/down run under sync and lockout: down-phase matches, one trigger per two.
        wr(12'h728, 16'h0103);
        wr(12'h758, 16'h0010);
        wr(12'h718, 16'h8003);
        apb(1'h1, 12'h700, 32'h8001);
        repeat (130) begin
            @(posedge clk);
            if (trig === 1'h1) n++;
        end
        chk(n, 32'h1);
        $display("trigger test done");
        test_done;
    end
endmodule : tb_top
